// ==== verilog/ptc_pkg.sv ====
// Package for the periodic timer control block: register map and types.
package ptc_pkg;
  localparam int CNT_W = 10;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT_LO = 8'h04;
  localparam logic [7:0] OFF_CNT_HI = 8'h08;
  localparam logic [7:0] OFF_CMPA_LO = 8'h0C;
  localparam logic [7:0] OFF_CMPA_HI = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1C;
  localparam logic [7:0] OFF_PIN = 8'h20;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [1:0] HI_BITS_ZERO = 2'h0;
  localparam int ST_W = 3;
  // Status bits: compare A match, period match, capture event.
  localparam int ST_A = 0;
  localparam int ST_P = 1;
  localparam int ST_CAP = 2;

  typedef enum logic [1:0] {
    MODE_CMP_OUT = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } ptc_mode_e;

  // Control register layout, bit 31 downward.
  typedef struct packed {
    logic [20:0] unused;
    logic run_enable;
    logic [1:0] pin_function;
    ptc_mode_e mode;
    logic [1:0] pin_func_rsv;
    logic output_initial_level_select;
    logic output_polarity_invert;
    logic capture_source_select;
    logic counter_clear_select;
  } ptc_ctrl_s;

  typedef struct packed {
    logic cmp_a;
    logic cmp_p;
    logic capture;
  } ptc_evt_s;
endpackage : ptc_pkg

// ==== verilog/ptc_timer.sv ====
// Periodic timer counter, comparators, output pin logic and AHB-Lite regs.
`timescale 1ns/1ps
module ptc_timer (
  input wire logic clk, // 100 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always OKAY
  input wire logic capture_input_pin, // capture input pin, async
  input wire logic external_timer_clock_pin, // external clock pin, async
  output logic timer_output_pin, // timer output pin
  output logic timer_output_pin_oe, // high while the pin is driven
  output logic irq // level interrupt
);
  ptc_pkg::ptc_ctrl_s ctrl_r;
  logic [9:0] counter_r;
  logic [9:0] compare_a_r;
  logic [9:0] period_r;
  logic [7:0] low_buf_r;
  logic [9:0] capture_r;
  logic [ptc_pkg::ST_W-1:0] status_r;
  logic [ptc_pkg::ST_W-1:0] mask_r;
  logic out_level_r;
  logic run_d_r;
  logic [1:0] cap_sync_r;
  logic [1:0] eck_sync_r;
  logic cap_d_r;
  logic eck_d_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_data;

  // Address phase captured for the data phase.
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans == ptc_pkg::HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_sync_r <= 2'h0;
      eck_sync_r <= 2'h0;
      cap_d_r <= 1'b0;
      eck_d_r <= 1'b0;
    end else begin
      cap_sync_r <= {cap_sync_r[0], capture_input_pin};
      eck_sync_r <= {eck_sync_r[0], external_timer_clock_pin};
      cap_d_r <= cap_sync_r[1];
      eck_d_r <= eck_sync_r[1];
    end
  end

  ptc_pkg::ptc_mode_e mode;
  logic run;
  logic run_rise;
  logic tick;
  logic match_a;
  logic match_p;
  logic clr_a_sel;
  logic clear_now;
  logic single_pulse;
  logic trig_lvl;
  logic trig_prev;
  logic cap_edge;

  // Modes in which the block owns the output pin.
  function automatic logic drives_pin(input ptc_pkg::ptc_mode_e m);
    logic d;
    d = 1'b0;
    if (m == ptc_pkg::MODE_CMP_OUT) begin
      d = 1'b1;
    end
    if (m == ptc_pkg::MODE_PWM) begin
      d = 1'b1;
    end
    return d;
  endfunction : drives_pin

  // Modes in which the counter clear select is honoured.
  function automatic logic honours_clear(input ptc_pkg::ptc_mode_e m);
    logic h;
    h = 1'b0;
    if (m == ptc_pkg::MODE_CMP_OUT) begin
      h = 1'b1;
    end
    if (m == ptc_pkg::MODE_TIMER) begin
      h = 1'b1;
    end
    return h;
  endfunction : honours_clear

  // Single pulse is the PWM mode with the last pin function code.
  function automatic logic pulse_mode(input ptc_pkg::ptc_mode_e m,
      input logic [1:0] pf);
    logic p;
    p = 1'b0;
    if (m == ptc_pkg::MODE_PWM) begin
      p = pf == 2'h3;
    end
    return p;
  endfunction : pulse_mode

  // Capture edge for the selected edge sense; the last code disables.
  function automatic logic capture_edge(input logic [1:0] pf,
      input logic lvl, input logic prev);
    logic e;
    e = 1'b0;
    unique case (pf)
      2'h0: e = lvl && !prev;
      2'h1: e = !lvl && prev;
      2'h2: e = lvl != prev;
      default: e = 1'b0;
    endcase
    return e;
  endfunction : capture_edge

  // Compare-out pin level after a compare A match, by pin function.
  function automatic logic match_level(input logic [1:0] pf,
      input logic cur);
    logic n;
    n = cur;
    unique case (pf)
      2'h0: n = cur;
      2'h1: n = 1'b0;
      2'h2: n = 1'b1;
      default: n = !cur;
    endcase
    return n;
  endfunction : match_level

  // mode field decoded straight into the mode enum.
  assign mode = ctrl_r.mode;
  assign run = ctrl_r.run_enable;
  assign run_rise = run && !run_d_r;
  // The counter is clocked by the system clock only; choosing another
  // counter clock source is left to the surrounding logic.
  // counter advances once per system clock while running.
  assign tick = run;
  // ten-bit comparators against compare A and period.
  assign match_a = tick && counter_r == compare_a_r;
  assign match_p = tick && counter_r == period_r;
  // clear select only honoured in compare and timer modes.
  assign clr_a_sel = ctrl_r.counter_clear_select && honours_clear(mode);
  assign single_pulse = pulse_mode(mode, ctrl_r.pin_function);
  always_comb begin
    clear_now = 1'b0;
    if (mode != ptc_pkg::MODE_CAPTURE) begin
      if (clr_a_sel) begin
        clear_now = match_a;
      end else if (period_r == ptc_pkg::CNT_ZERO) begin
        // overflow clear only when period value is zero.
        clear_now = tick && counter_r == ptc_pkg::CNT_MAX;
      end else begin
        clear_now = match_p;
      end
    end
  end

  assign trig_lvl = ctrl_r.capture_source_select ? eck_sync_r[1] : cap_sync_r[1];
  assign trig_prev = ctrl_r.capture_source_select ? eck_d_r : cap_d_r;
  assign cap_edge = capture_edge(ctrl_r.pin_function, trig_lvl, trig_prev);

  // Counter.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_r <= ptc_pkg::CNT_ZERO;
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
      // rising run enable zeroes; falling leaves the value held.
      if (run_rise) begin
        counter_r <= ptc_pkg::CNT_ZERO;
      // the clear takes effect on the matching tick.
      end else if (clear_now) begin
        counter_r <= ptc_pkg::CNT_ZERO;
      end else if (tick) begin
        counter_r <= counter_r + 10'h001;
      end
    end
  end

  // Capture register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_r <= ptc_pkg::CNT_ZERO;
    end else if (mode == ptc_pkg::MODE_CAPTURE && run && cap_edge) begin
      capture_r <= counter_r;
    end
  end

  // Output level before polarity.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_level_r <= 1'b0;
    end else if (run_rise) begin
      // level starts at the initial level select on run enable rise.
      out_level_r <= ctrl_r.output_initial_level_select;
    end else if (mode == ptc_pkg::MODE_CMP_OUT && match_a &&
                 compare_a_r != ptc_pkg::CNT_ZERO) begin
      out_level_r <= match_level(ctrl_r.pin_function, out_level_r);
    end else if (single_pulse && match_a) begin
      out_level_r <= !ctrl_r.output_initial_level_select;
    end
  end

  logic pwm_active;
  logic pin_pre;
  logic [10:0] period_len;
  assign period_len = (period_r == ptc_pkg::CNT_ZERO) ? 11'h400 : {1'b0, period_r};
  assign pwm_active = {1'b0, counter_r} < {1'b0, compare_a_r} ||
    {1'b0, compare_a_r} >= period_len;
  // Changing the pin function while running gives an unpredictable
  // waveform; software should stop the timer first.
  always_comb begin
    pin_pre = out_level_r;
    if (mode == ptc_pkg::MODE_PWM && !single_pulse) begin
      // active level chosen by the initial level select.
      unique case (ctrl_r.pin_function)
        2'h0: pin_pre = !ctrl_r.output_initial_level_select;
        2'h1: pin_pre = ctrl_r.output_initial_level_select;
        default: pin_pre = (pwm_active && run) ?
          ctrl_r.output_initial_level_select :
          !ctrl_r.output_initial_level_select;
      endcase
    end
  end

  // timer mode drives nothing, so neither bit reaches the pin.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin_oe <= drives_pin(mode);
      if (!drives_pin(mode)) begin
        timer_output_pin <= 1'b0;
      end else begin
        timer_output_pin <= pin_pre ^ ctrl_r.output_polarity_invert;
      end
    end
  end

  // Bus write path and registers. With no wait states the write data
  // arrives one cycle after the address, so the address is held here.
  logic wr_en;
  logic rd_hi;
  assign wr_en = wr_pend_r;
  assign rd_hi = addr_ok && !hwrite && haddr[7:0] == ptc_pkg::OFF_CNT_HI;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= '0;
      compare_a_r <= ptc_pkg::CNT_ZERO;
      period_r <= ptc_pkg::CNT_ZERO;
      mask_r <= '0;
    end else if (wr_en) begin
      unique case (wr_addr_r)
        ptc_pkg::OFF_CTRL: ctrl_r <= ptc_pkg::ptc_ctrl_s'({21'h0, hwdata[10:0]});
        // compare A low and high bytes.
        ptc_pkg::OFF_CMPA_LO: compare_a_r[7:0] <= hwdata[7:0];
        ptc_pkg::OFF_CMPA_HI: compare_a_r[9:8] <= hwdata[1:0];
        ptc_pkg::OFF_PERIOD: period_r <= hwdata[9:0];
        ptc_pkg::OFF_MASK: mask_r <= hwdata[ptc_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // high byte read latches the low byte into the buffer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_buf_r <= 8'h00;
    end else if (rd_hi) begin
      low_buf_r <= counter_r[7:0];
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  ptc_pkg::ptc_evt_s evt;
  logic a_flag_ok;
  assign a_flag_ok = compare_a_r != ptc_pkg::CNT_ZERO || mode == ptc_pkg::MODE_PWM;
  assign evt.cmp_a = match_a && a_flag_ok && mode != ptc_pkg::MODE_CAPTURE;
  assign evt.cmp_p = match_p && !clr_a_sel && mode != ptc_pkg::MODE_CAPTURE;
  assign evt.capture = mode == ptc_pkg::MODE_CAPTURE && run && cap_edge;
  logic [ptc_pkg::ST_W-1:0] evt_v;
  logic [ptc_pkg::ST_W-1:0] clr_v;
  always_comb begin
    evt_v = '0;
    evt_v[ptc_pkg::ST_A] = evt.cmp_a;
    evt_v[ptc_pkg::ST_P] = evt.cmp_p;
    evt_v[ptc_pkg::ST_CAP] = evt.capture;
    clr_v = '0;
    if (wr_en && wr_addr_r == ptc_pkg::OFF_STATUS) begin
      clr_v = hwdata[ptc_pkg::ST_W-1:0];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clr_v) | evt_v;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_r & ~clr_v | evt_v) & mask_r);
    end
  end

  // Read mux; upper bits of the high bytes read zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (haddr[7:0])
      ptc_pkg::OFF_CTRL: rd_data = 32'(ctrl_r);
      ptc_pkg::OFF_CNT_LO: rd_data = {24'h0, low_buf_r};
      ptc_pkg::OFF_CNT_HI: rd_data = {30'h0, counter_r[9:8]};
      ptc_pkg::OFF_CMPA_LO: rd_data = {24'h0, compare_a_r[7:0]};
      ptc_pkg::OFF_CMPA_HI: rd_data = {30'h0, compare_a_r[9:8]};
      ptc_pkg::OFF_PERIOD: rd_data = {22'h0, period_r};
      ptc_pkg::OFF_STATUS: rd_data = {29'h0, status_r};
      ptc_pkg::OFF_MASK: rd_data = {29'h0, mask_r};
      ptc_pkg::OFF_PIN: rd_data = {22'h0, capture_r};
      default: rd_data = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_data;
    end
  end
endmodule : ptc_timer

// ==== testbench/ptc_chk.sv ====
// Port checker for the periodic timer block, bound to its top module.
`timescale 1ns/1ps
module ptc_chk (
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic [31:0] hwdata, // wdata
  input wire logic hready, // ready
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic timer_output_pin, // pin
  input wire logic timer_output_pin_oe // pin enable
);
  ptc_pkg::ptc_ctrl_s ctrl_r;
  logic [9:0] cmpa_r;
  logic [7:0] a_r;
  logic wr_r;
  wire logic ap = hsel && hready && htrans == ptc_pkg::HTRANS_NONSEQ;
  // Shadow copies of control and compare A, taken from bus writes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= 1'h0;
      a_r <= 8'h00;
    end else if (hready) begin
      wr_r <= ap && hwrite;
      a_r <= haddr[7:0];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= '0;
      cmpa_r <= 10'h000;
    end else if (wr_r && hready) begin
      if (a_r == ptc_pkg::OFF_CTRL) ctrl_r <= hwdata;
      if (a_r == ptc_pkg::OFF_CMPA_LO) cmpa_r[7:0] <= hwdata[7:0];
      if (a_r == ptc_pkg::OFF_CMPA_HI) cmpa_r[9:8] <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [7:0] a);
    ap && !hwrite && haddr[7:0] == a && !wr_r;
  endsequence
  sequence s_run_rise;
    $rose(ctrl_r.run_enable) && !ctrl_r.mode[0] && cmpa_r > 10'h008 &&
      (!ctrl_r.mode[1] || ctrl_r.pin_function[1]);
  endsequence
  property p_oe_off;
    ctrl_r.mode[0] [*3] |-> !timer_output_pin_oe;
  endproperty
  property p_oe_on;
    !ctrl_r.mode[0] [*3] |-> timer_output_pin_oe;
  endproperty
  property p_cnt_hi;
    s_rd(ptc_pkg::OFF_CNT_HI) |=> hrdata[31:2] == 30'h0;
  endproperty
  property p_cnt_lo;
    s_rd(ptc_pkg::OFF_CNT_LO) |=> hrdata[31:8] == 24'h0;
  endproperty
  property p_cmpa_lo;
    s_rd(ptc_pkg::OFF_CMPA_LO) |=> hrdata == {24'h0, cmpa_r[7:0]};
  endproperty
  property p_cmpa_hi;
    s_rd(ptc_pkg::OFF_CMPA_HI) |=> hrdata == {30'h0, cmpa_r[9:8]};
  endproperty
  property p_pin_init;
    s_run_rise |-> ##[1:3] timer_output_pin ==
      (ctrl_r.output_initial_level_select ^ ctrl_r.output_polarity_invert);
  endproperty
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin enabled");
  a_oe_on: assert property (p_oe_on) else $error("pin not enabled");
  a_cnt_hi: assert property (p_cnt_hi) else $error("high bits");
  a_cnt_lo: assert property (p_cnt_lo) else $error("low byte");
  a_cmpa_lo: assert property (p_cmpa_lo) else $error("compare low");
  a_cmpa_hi: assert property (p_cmpa_hi) else $error("compare hi");
  a_pin_init: assert property (p_pin_init) else $error("pin");
  a_bus: assert property (p_bus) else $error("bus response");
endmodule : ptc_chk
bind ptc_timer ptc_chk u_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe));

// ==== testbench/ptc_pins.sv ====
// Model of the timer input pins, giving edges on request.
`timescale 1ns/1ps
module ptc_pins (
  input wire logic clk, // clock
  input wire logic cap_go, // pulse the capture pin
  input wire logic ext_go, // pulse the clock pin
  output logic capture_input_pin, // capture pin
  output logic external_timer_clock_pin // clock pin
);
  logic [3:0] cap_r = 4'h0;
  logic [3:0] ext_r = 4'h0;
  // Each request gives a four-cycle high pulse; idle level is low.
  always_ff @(posedge clk) begin
    cap_r <= {cap_r[2:0], cap_go};
    ext_r <= {ext_r[2:0], ext_go};
  end
  assign capture_input_pin = |cap_r;
  assign external_timer_clock_pin = |ext_r;
endmodule : ptc_pins

// ==== testbench/tb_top.sv ====
// Self-checking bench for the periodic timer block over AHB-Lite.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic cap_go = 1'h0;
  logic ext_go = 1'h0;
  logic [31:0] hrdata, q;
  logic [9:0] v;
  logic hreadyout, hresp, cap_pin, ext_pin, pin, oe, irq;
  int n_fail = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  ptc_timer dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_input_pin(cap_pin),
    .external_timer_clock_pin(ext_pin), .timer_output_pin(pin),
    .timer_output_pin_oe(oe), .irq(irq));
  ptc_pins u_pins (.clk(clk), .cap_go(cap_go), .ext_go(ext_go),
    .capture_input_pin(cap_pin), .external_timer_clock_pin(ext_pin));
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= ptc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= ptc_pkg::HSIZE_WORD;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    q = hrdata;
  endtask : bus
  task automatic rcnt(input int gap);
    bus(1'h0, ptc_pkg::OFF_CNT_HI, 32'h0);
    v[9:8] = q[1:0];
    repeat (gap) @(posedge clk);
    bus(1'h0, ptc_pkg::OFF_CNT_LO, 32'h0);
    v[7:0] = q[7:0];
  endtask : rcnt
  task automatic pulse(input logic e);
    if (e) ext_go <= 1'h1;
    else cap_go <= 1'h1;
    @(posedge clk);
    ext_go <= 1'h0;
    cap_go <= 1'h0;
    repeat (10) @(posedge clk);
  endtask : pulse
  // Control word: mode, pin function, run, then bits 3 to 0.
  function automatic logic [31:0] cw(input logic [1:0] m,
      input logic [1:0] pf, input logic run, input logic [3:0] lo);
    return {21'h0, run, pf, m, 2'h0, lo};
  endfunction : cw
  initial begin
    logic [7:0] ra [5];
    ra = '{ptc_pkg::OFF_CNT_LO, ptc_pkg::OFF_CNT_HI, ptc_pkg::OFF_CMPA_LO,
      ptc_pkg::OFF_CMPA_HI, 8'h40};
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    foreach (ra[i]) begin
      bus(1'h0, ra[i], 32'h0);
      chk(q, 32'h0);
    end
    bus(1'h1, ptc_pkg::OFF_CMPA_LO, 32'hFFFF_FFA5);
    bus(1'h1, ptc_pkg::OFF_CMPA_HI, 32'hFFFF_FFFF);
    bus(1'h1, ptc_pkg::OFF_CNT_LO, 32'h0000_00FF);
    bus(1'h0, ptc_pkg::OFF_CMPA_LO, 32'h0);
    chk(q, 32'h0000_00A5);
    bus(1'h0, ptc_pkg::OFF_CMPA_HI, 32'h0);
    chk(q, 32'h0000_0003);
    bus(1'h0, ptc_pkg::OFF_CNT_LO, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      bus(1'h1, ptc_pkg::OFF_CTRL, cw(i[3:2], 2'h3, 1'h0, {i[1:0], 2'h0}));
      bus(1'h1, ptc_pkg::OFF_CTRL, cw(i[3:2], 2'h3, 1'h1, {i[1:0], 2'h0}));
      repeat (4) @(posedge clk);
      chk(32'(oe), 32'(!i[2]));
      if (!i[2]) chk(32'(pin), 32'(i[1] ^ i[0]));
    end
    bus(1'h1, ptc_pkg::OFF_CMPA_HI, 32'h0);
    bus(1'h1, ptc_pkg::OFF_CMPA_LO, 32'h10);
    bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h2, 2'h2, 1'h0, 4'h8));
    bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h2, 2'h2, 1'h1, 4'h8));
    repeat (4) @(posedge clk);
    chk(32'(pin), 32'h1);
    repeat (30) @(posedge clk);
    chk(32'(pin), 32'h0);
    for (int c = 0; c < 2; c++) begin
      bus(1'h1, ptc_pkg::OFF_PERIOD, 32'h1E);
      bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h3, 2'h0, 1'h0, 4'(c)));
      bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h3, 2'h0, 1'h1, 4'(c)));
      repeat (100) @(posedge clk);
      rcnt(0);
      chk(32'(v <= (c ? 10'h010 : 10'h01E)), 32'h1);
    end
    bus(1'h1, ptc_pkg::OFF_PERIOD, 32'h0);
    bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h3, 2'h0, 1'h0, 4'h0));
    bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h3, 2'h0, 1'h1, 4'h0));
    repeat (200) @(posedge clk);
    rcnt(100);
    chk(32'(v >= 10'd198 && v <= 10'd206), 32'h1);
    bus(1'h1, ptc_pkg::OFF_MASK, 32'h4);
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, ptc_pkg::OFF_CTRL, cw(2'h1, 2'h0, 1'h1, {2'h0, s[0], 1'h0}));
      bus(1'h1, ptc_pkg::OFF_STATUS, 32'h7);
      pulse(!s[0]);
      bus(1'h0, ptc_pkg::OFF_STATUS, 32'h0);
      chk(32'(q[2]), 32'h0);
      pulse(s[0]);
      bus(1'h0, ptc_pkg::OFF_STATUS, 32'h0);
      chk(32'(q[2]), 32'h1);
      chk(32'(irq), 32'h1);
    end
    bus(1'h1, ptc_pkg::OFF_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'h1, ptc_pkg::OFF_MASK, 32'h0);
    pulse(1'h1);
    chk(32'(irq), 32'h0);
    final_report();
  end
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule : tb_top
